// ### hw/pulse_template_pkg.sv
// Overview of operation
// - Six-bit amplitude scale multiplies user pulse amplitude; resets to 100001.
// - Short-haul T1, J1 and 0 dB build-out: nominal 110110, 2% per step.
// - The -7.5 dB build-out: nominal 010001, 6.25% per step.
// - The -15.0 dB build-out: nominal 001000, 12.5% per step.
// - The -22.5 dB build-out: nominal 000100, 25% per step.
// - E1 75 and 120 ohm templates: nominal 100001, 3% per step.
// - Writing one to launch bit 7 starts the addressed template RAM access.
// - Bit 6 picks direction: zero writes the RAM, one reads it.
// - Bits 5-4 pick one of four unit intervals, 00 the leftmost.
// - Bits 3-0 pick one of sixteen samples, 0000 the leftmost.
// - Write stores the 7-bit data field; read returns the sample there.
package pulse_template_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] scale_offset   = 8'h07;
  localparam logic [7:0] access_offset  = 8'h08;
  localparam logic [7:0] data_offset    = 8'h09;

  // Reset values.
  localparam logic [5:0] scale_reset    = 6'h21;
  localparam logic [7:0] access_reset   = 8'h00;
  localparam logic [6:0] data_reset     = 7'h00;

  // Field positions of the access control register.
  localparam int launch_bit    = 7;
  localparam int direction_bit = 6;
  localparam int interval_hi   = 5;
  localparam int interval_lo   = 4;
  localparam int sample_hi     = 3;
  localparam int sample_lo     = 0;

  // Widths of the template RAM.
  localparam int ram_addr_w = 6;
  localparam int ram_data_w = 7;

  // Nominal scale codes per template group.
  localparam logic [5:0] nominal_short  = 6'h36;
  localparam logic [5:0] nominal_lbo75  = 6'h11;
  localparam logic [5:0] nominal_lbo150 = 6'h08;
  localparam logic [5:0] nominal_lbo225 = 6'h04;
  localparam logic [5:0] nominal_e1     = 6'h21;

  // Amplitude change per scale step, in hundredths of a percent.
  localparam logic [11:0] step_short  = 12'h0c8;
  localparam logic [11:0] step_lbo75  = 12'h271;
  localparam logic [11:0] step_lbo150 = 12'h4e2;
  localparam logic [11:0] step_lbo225 = 12'h9c4;
  localparam logic [11:0] step_e1     = 12'h12c;

  // Template select codes that matter here.
  localparam logic [3:0] tpl_e1_120   = 4'h1;
  localparam logic [3:0] tpl_ds1_0db  = 4'h8;
  localparam logic [3:0] tpl_ds1_75   = 4'h9;
  localparam logic [3:0] tpl_ds1_150  = 4'ha;
  localparam logic [3:0] tpl_ds1_225  = 4'hb;

  // Sequencer of the indirect access.
  typedef enum logic [1:0] {st_idle, st_access, st_capture} access_state_t;

endpackage

// ### hw/template_ram.sv
`timescale 1ns/1ps
// Pulse template store, four unit intervals by sixteen samples.
module template_ram
  import pulse_template_pkg::*;
(
  // Clock.
  input  wire logic                  sys_clk,
  // Access port.
  input  wire logic                  wr_en,
  input  wire logic [ram_addr_w-1:0] addr,
  input  wire logic [ram_data_w-1:0] wr_data,
  output logic      [ram_data_w-1:0] rd_data
);

  logic [ram_data_w-1:0] mem [2**ram_addr_w];

  // Read data leaves through a register, so a read costs one cycle.
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule // template_ram

// ### hw/pulse_template_ram_access.sv
`timescale 1ns/1ps
// Scale register and indirect template RAM port of the transmit shaper.
module pulse_template_ram_access
  import pulse_template_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Control register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Template chosen in the template config register.
  input  wire logic [3:0]  template_select,
  // Scaling towards the waveform shaper.
  output logic      [5:0]  amplitude_scale,
  output logic      [5:0]  nominal_scale,
  output logic      [11:0] scale_step,
  output logic      [12:0] scaled_amplitude,
  output logic             access_busy
);

  // Nominal scale of a template group.
  function automatic logic [5:0] nominal_of(input logic [3:0] tpl);
    if (tpl <= tpl_e1_120 || tpl[3:2] == 2'b11) return nominal_e1;
    else if (tpl <= tpl_ds1_0db) return nominal_short;
    else if (tpl == tpl_ds1_75) return nominal_lbo75;
    else if (tpl == tpl_ds1_150) return nominal_lbo150;
    else return nominal_lbo225;
  endfunction

  // Amplitude change per step of a template group.
  function automatic logic [11:0] step_of(input logic [3:0] tpl);
    if (tpl <= tpl_e1_120 || tpl[3:2] == 2'b11) return step_e1;
    else if (tpl <= tpl_ds1_0db) return step_short;
    else if (tpl == tpl_ds1_75) return step_lbo75;
    else if (tpl == tpl_ds1_150) return step_lbo150;
    else return step_lbo225;
  endfunction

  access_state_t         state;
  access_state_t         next_state;
  logic [5:0]            scale;
  logic [7:0]            access_ctrl;
  logic [6:0]            sample_data;
  logic [ram_data_w-1:0] ram_rd_data;

  // Address decode of the three registers.
  wire hit_scale  = reg_addr == scale_offset;
  wire hit_access = reg_addr == access_offset;
  wire hit_data   = reg_addr == data_offset;

  // A launch is only taken while idle; access and data writes during an access are dropped.
  wire launch     = reg_wr && hit_access && reg_wdata[launch_bit]
                    && state == st_idle;
  wire ctrl_write = reg_wr && hit_access && state == st_idle;
  wire data_write = reg_wr && hit_data && state == st_idle;

  // RAM address is interval then sample; zero codes are the leftmost.
  wire [ram_addr_w-1:0] ram_addr = {access_ctrl[interval_hi:interval_lo],
                                    access_ctrl[sample_hi:sample_lo]};
  wire ram_wr = state == st_access && !access_ctrl[direction_bit];

  // Sequencer: write finishes in one cycle, read needs a capture cycle.
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (launch) next_state = st_access;
      end
      st_access: begin
        next_state = access_ctrl[direction_bit] ? st_capture : st_idle;
      end
      st_capture: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) state <= st_idle;
    else     state <= next_state;
  end

  // Scale register; the reset value suits the E1 templates.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scale <= scale_reset;
    end else if (reg_wr && hit_scale) begin
      scale <= reg_wdata[5:0];
    end
  end

  // Access control; launch clears itself when the access ends.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      access_ctrl <= access_reset;
    end else if (ctrl_write) begin
      access_ctrl <= reg_wdata;
    end else if (next_state == st_idle && state != st_idle) begin
      access_ctrl[launch_bit] <= 1'b0;
    end
  end

  // Data register feeds writes and catches read results.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sample_data <= data_reset;
    end else if (state == st_capture) begin
      sample_data <= ram_rd_data;
    end else if (data_write) begin
      sample_data <= reg_wdata[6:0];
    end
  end

  template_ram u_ram (
    .sys_clk (sys_clk),
    .wr_en   (ram_wr),
    .addr    (ram_addr),
    .wr_data (sample_data),
    .rd_data (ram_rd_data)
  );

  // Register read data; reserved bits and unmapped offsets read zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= hit_scale  ? {2'b00, scale} :
                   hit_access ? access_ctrl :
                   hit_data   ? {1'b0, sample_data} : 8'h00;
    end
  end

  // Scaling info for the shaper; step size follows the template group.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nominal_scale    <= scale_reset;
      scale_step       <= step_e1;
      scaled_amplitude <= 13'h0000;
    end else begin
      nominal_scale    <= nominal_of(template_select);
      scale_step       <= step_of(template_select);
      scaled_amplitude <= sample_data * scale;
    end
  end

  assign amplitude_scale = scale;
  assign access_busy     = access_ctrl[launch_bit];

  // Checks of the access sequence and the scaling outputs.
  sequence read_launch_s;
    state == st_idle && launch && reg_wdata[direction_bit];
  endsequence

  sequence read_done_s;
    state == st_access ##1 state == st_capture ##1 state == st_idle;
  endsequence

  launch_starts_a: assert property (@(posedge sys_clk) disable iff (rst)
    launch |=> state == st_access && access_ctrl[launch_bit])
    else $error("Launch did not start an access.");
  read_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    read_launch_s |=> read_done_s ##0 sample_data == $past(ram_rd_data))
    else $error("Read result not captured.");
  write_strobe_a: assert property (@(posedge sys_clk) disable iff (rst)
    ram_wr |-> state == st_access && !access_ctrl[direction_bit])
    else $error("RAM written outside a write access.");
  launch_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    launch |-> ##[2:3] !access_ctrl[launch_bit])
    else $error("Launch bit not cleared.");
  addr_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    ram_addr[5:4] == access_ctrl[5:4] && ram_addr[3:0] == access_ctrl[3:0])
    else $error("RAM address does not follow the fields.");
  scale_reset_a: assert property (@(posedge sys_clk)
    $past(rst) |-> amplitude_scale == 6'h21)
    else $error("Scale reset value wrong.");
  lbo_nominal_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(template_select) == tpl_ds1_75 && !$past(rst)
    |-> nominal_scale == 6'h11 && scale_step == 12'h271)
    else $error("Build-out nominal wrong.");
  e1_nominal_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(template_select) <= 4'h1 && !$past(rst)
    |-> nominal_scale == 6'h21 && scale_step == 12'h12c)
    else $error("E1 nominal wrong.");
  product_a: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> scaled_amplitude == 13'($past(sample_data) * $past(scale)))
    else $error("Scaled amplitude wrong.");

endmodule // pulse_template_ram_access

// ### verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the scale register and indirect template port.
module testbench;
  import pulse_template_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [3:0]  template_select = 4'h0;
  logic [7:0]  reg_rdata;
  logic [5:0]  amplitude_scale;
  logic [5:0]  nominal_scale;
  logic [11:0] scale_step;
  logic [12:0] scaled_amplitude;
  logic        access_busy;
  logic [6:0]  mem [64];
  logic [7:0]  rd_v;
  logic [5:0]  a;
  logic [6:0]  d;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;

  pulse_template_ram_access dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .template_select(template_select), .amplitude_scale(amplitude_scale),
    .nominal_scale(nominal_scale), .scale_step(scale_step),
    .scaled_amplitude(scaled_amplitude), .access_busy(access_busy));

  always #50 sys_clk = ~sys_clk;

  // Polls give up after ten cycles; the whole run is also capped at 20000 cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Nominal scale and step per template code, step in 0.01 percent.
  function automatic logic [17:0] exp_tpl(input logic [3:0] t);
    if (t >= 4'h2 && t <= 4'h8) return {6'h36, 12'd200};
    if (t == 4'h9) return {6'h11, 12'd625};
    if (t == 4'ha) return {6'h08, 12'd1250};
    if (t == 4'hb) return {6'h04, 12'd2500};
    return {6'h21, 12'd300};
  endfunction

  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge sys_clk);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] ad);
    @(negedge sys_clk);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (access_busy !== 1'b0 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    check({15'h0, access_busy}, 16'h0);
  endtask

  // A second launch lands while the read runs and must be dropped.
  task ram_read(input logic [5:0] ad);
    wr(8'h08, {2'b11, ad});
    check({15'h0, access_busy}, 16'h1);
    wr(8'h08, {2'b10, ~ad});
    wait_idle();
    rd(8'h08);
    check({8'h0, rd_v}, {10'h1, ad});
    rd(8'h09);
    check({8'h0, rd_v}, {9'h0, mem[ad]});
  endtask

  initial begin
    $urandom(92356);
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    rd(8'h07);
    check({8'h0, rd_v}, 16'h21);
    rd(8'h08);
    check({8'h0, rd_v}, 16'h00);
    check({10'h0, amplitude_scale}, 16'h21);
    rd(8'h0a);
    check({8'h0, rd_v}, 16'h00);
    $display("Reset test done");
    for (int t = 0; t < 16; t++) begin
      template_select = t[3:0];
      repeat (2) @(negedge sys_clk);
      check({10'h0, nominal_scale}, {10'h0, exp_tpl(t[3:0]) >> 12});
      check({4'h0, scale_step}, {4'h0, exp_tpl(t[3:0]) & 18'hfff});
    end
    $display("Template test done");
    wr(8'h07, 8'hff);
    rd(8'h07);
    check({8'h0, rd_v}, 16'h3f);
    for (int i = 0; i < 64; i++) begin
      a = i[5:0];
      d = (i < 2) ? {7{i[0]}} : 7'($urandom);
      template_select = 4'($urandom);
      wr(8'h09, {1'b0, d});
      wr(8'h08, {2'b10, a});
      wait_idle();
      mem[a] = d;
    end
    for (int i = 0; i < 40; i++) ram_read((i < 2) ? {6{i[0]}} : 6'($urandom));
    $display("Template RAM test done");
    repeat (4) begin
      d = 7'($urandom);
      a = 6'($urandom);
      wr(8'h07, {2'b00, a});
      wr(8'h09, {1'b0, d});
      repeat (2) @(negedge sys_clk);
      check({3'h0, scaled_amplitude}, 16'(d) * 16'(a));
    end
    $display("Scaling test done");
    give_verdict();
  end
endmodule // testbench
